/* pkg/otpst_defines.svh */
/*
 * Constants of the feature and status register block: commands, feature
 * addresses, bit positions, reset values and operation times.
 * Assumes a 10 MHz core clock and an SPI mode 0/3 host.
 */
`ifndef OTPST_DEFINES_SVH
`define OTPST_DEFINES_SVH
// ==========================================================================
// Commands
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_GETF 8'h0F
`define CMD_SETF 8'h1F
`define CMD_PREAD 8'h13
`define CMD_PEXEC 8'h10
`define CMD_BERASE 8'hD8
`define CMD_RESET 8'hFF
// ==========================================================================
// Feature addresses and bit positions
`define ADR_CONFIG 8'hB0
`define ADR_STATUS 8'hC0
`define CFG_LOCK 7
`define CFG_OTPEN 6
`define CFG_ECCEN 4
`define CFG_QUAD 0
`define CFG_RESET 8'h10
`define ST_ECC_HI 5
`define ST_ECC_LO 4
`define ST_PFAIL 3
`define ST_EFAIL 2
`define ST_WLATCH 1
`define ST_BUSYBIT 0
// ==========================================================================
// Array geometry: four OTP pages, 64 pages per block, 18 valid row bits
`define OTP_PAGES 24'h000004
`define ROW_TOP 23
`define ROW_VALID 18
`define ADDR_BYTES 2'h3
// ==========================================================================
// Times in ns and the clock period
`define CLK_NS 100
`define T_READ_NS 300000
`define T_PROG_NS 600000
`define T_ERASE_NS 10000000
`define T_RST_NS 500000
`endif

/* pkg/otpst_pkg.sv */
/*
 * Types of the feature and status register block.
 * Assumes otpst_defines.svh is on the include path.
 */
package otpst_pkg;
	// ======================================================================
	// Operation kinds and the request handed to the array engine
	typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_LOCK} otpst_op_t;
	typedef struct packed {
		logic valid;
		otpst_op_t kind;
		logic otpSel;
		logic [23:0] row;
	} otpst_req_t;
	// ECC decode outcome from the array engine
	typedef struct packed {
		logic valid;
		logic [1:0] code;
	} otpst_ecc_t;
	typedef enum {ST_IDLE, ST_BUSY} otpst_state_t;
endpackage : otpst_pkg

/* verilog/otp_status_regs.sv */
/*
 * Feature and status registers of a serial NAND, reached over SPI with the
 * get-feature and set-feature commands; it also times the busy phases.
 * Assumes an SPI mode 0/3 host whose clock is far slower than mclk, and an
 * array engine that reports ECC outcomes on the mclk domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "otpst_defines.svh"

module otp_status_regs #(
	parameter int PROG_CYC = `T_PROG_NS / `CLK_NS,
	parameter int ERASE_CYC = `T_ERASE_NS / `CLK_NS,
	parameter int RST_CYC = `T_RST_NS / `CLK_NS
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic csPin_n,
	input wire logic mosi,
	output logic miso,
	output logic misoOe_n,
	input wire logic lockNv,
	input wire logic blockProtected,
	input wire otpst_pkg::otpst_ecc_t eccIn,
	output otpst_pkg::otpst_req_t arrayReq,
	output logic lockBurn,
	output logic [7:0] configOut
);
	import otpst_pkg::*;

	localparam int READ_CYC = `T_READ_NS / `CLK_NS;

	// ======================================================================
	// Pin synchronisers; stage one is read only by stage two.
	logic [2:0] sclkS_r, csS_r, mosiS_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclkS_r <= 3'h0;
			csS_r <= 3'h7;
			mosiS_r <= 3'h0;
		end else begin
			sclkS_r <= {sclkS_r[1:0], sclk};
			csS_r <= {csS_r[1:0], csPin_n};
			mosiS_r <= {mosiS_r[1:0], mosi};
		end
	end

	// Edges are found between stages two and three.
	wire sel = ~csS_r[1];
	wire sclkRise = sel & sclkS_r[1] & ~sclkS_r[2];
	wire sclkFall = sel & ~sclkS_r[1] & sclkS_r[2];
	wire frameEnd = csS_r[1] & ~csS_r[2];
	wire frameStart = ~csS_r[1] & csS_r[2];

	// ======================================================================
	// Byte assembly on the rising SCLK edge.
	logic [2:0] bitCnt_r;
	logic [7:0] shiftIn_r, cmd_r, fadr_r;
	logic [1:0] byteCnt_r;
	logic [23:0] row_r;
	wire [7:0] byteNow = {shiftIn_r[6:0], mosiS_r[1]};
	wire byteDone = sclkRise & (bitCnt_r == 3'h7);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bitCnt_r <= 3'h0;
			shiftIn_r <= 8'h00;
			byteCnt_r <= 2'h0;
			cmd_r <= 8'h00;
			fadr_r <= 8'h00;
			row_r <= 24'h000000;
		end else if (frameStart) begin
			bitCnt_r <= 3'h0;
			byteCnt_r <= 2'h0;
			cmd_r <= 8'h00;
		end else if (sclkRise) begin
			bitCnt_r <= bitCnt_r + 3'h1;
			shiftIn_r <= byteNow;
			if (byteDone) begin
				if (byteCnt_r != `ADDR_BYTES)
					byteCnt_r <= byteCnt_r + 2'h1;
				if (byteCnt_r == 2'h0)
					cmd_r <= byteNow;
				if (byteCnt_r == 2'h1)
					fadr_r <= byteNow;
				if (byteCnt_r != 2'h0)
					row_r <= {row_r[15:0], byteNow};
			end
		end
	end

	// ======================================================================
	// Feature and status state.
	logic otpEn_r, lockReq_r, eccEn_r, quadEn_r, locked_r;
	logic pFail_r, eFail_r, wrLatch_r;
	logic [1:0] ecc_r;
	otpst_state_t state_r;
	otpst_op_t op_r;
	logic opFail_r;
	logic [16:0] busyCnt_r;
	logic rstOp_r;

	wire busy = (state_r == ST_BUSY);
	// End of a timed array operation; the reset phase never counts as one.
	wire opDone = busy & (busyCnt_r == 17'h00001) & ~rstOp_r;
	wire [7:0] configReg = {locked_r | lockReq_r, otpEn_r, 1'b0, eccEn_r, 3'h0, quadEn_r};
	wire [7:0] statusReg = {2'h0, ecc_r, pFail_r, eFail_r, wrLatch_r, busy};
	assign configOut = configReg;

	// Commands act when the frame closes, set-feature when its data byte ends; only get-feature
	// and reset may run while busy, so only a reset disturbs a half-done operation.
	wire endCmd = frameEnd & (byteCnt_r != 2'h0);
	wire hasRow = (byteCnt_r == `ADDR_BYTES);
	wire doReset = endCmd & (cmd_r == `CMD_RESET);
	wire doWren = endCmd & ~busy & (cmd_r == `CMD_WREN);
	wire doWrdi = endCmd & ~busy & (cmd_r == `CMD_WRDI);
	wire doRead = endCmd & ~busy & hasRow & (cmd_r == `CMD_PREAD);
	wire doProg = endCmd & ~busy & hasRow & wrLatch_r & (cmd_r == `CMD_PEXEC);
	wire doErase = endCmd & ~busy & hasRow & wrLatch_r & (cmd_r == `CMD_BERASE);
	wire cfgWrite = byteDone & ~busy & (byteCnt_r == 2'h2) & (cmd_r == `CMD_SETF)
		& (fadr_r == `ADR_CONFIG);

	// Target checks; rows above the array or OTP pages beyond 03 are invalid.
	function automatic logic rowBad(input logic [23:0] r, input logic otp);
		rowBad = (r[`ROW_TOP:`ROW_VALID] != '0) | (otp & (r >= `OTP_PAGES));
	endfunction : rowBad
	wire lockSeq = otpEn_r & lockReq_r & ~locked_r;
	wire progBad = rowBad(row_r, otpEn_r) & ~lockSeq
		| (otpEn_r & locked_r) | (~otpEn_r & blockProtected);
	wire eraseBad = rowBad(row_r, 1'b0) | otpEn_r | blockProtected;

	// Configuration writes; the lock request cannot be set again once burnt.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			otpEn_r <= 1'b0;
			lockReq_r <= 1'b0;
			eccEn_r <= 1'(`CFG_RESET >> `CFG_ECCEN);
			quadEn_r <= 1'b0;
		end else if (doReset) begin
			otpEn_r <= 1'b0;
			lockReq_r <= 1'b0;
		end else if (cfgWrite) begin
			otpEn_r <= byteNow[`CFG_OTPEN];
			lockReq_r <= byteNow[`CFG_LOCK] & ~locked_r;
			eccEn_r <= byteNow[`CFG_ECCEN];
			quadEn_r <= byteNow[`CFG_QUAD];
		end
	end

	// The lock is nonvolatile: it is taken from the stored copy after reset
	// release and set for good by the locking program.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			locked_r <= 1'b0;
		else if (opDone & (op_r == OP_LOCK) & ~opFail_r)
			locked_r <= 1'b1;
		else if (lockNv)
			locked_r <= 1'b1;
	end

	// Write-enable latch; a started program or erase consumes it.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			wrLatch_r <= 1'b0;
		else if (doWren)
			wrLatch_r <= 1'b1;
		else if (doWrdi | doProg | doErase | doReset)
			wrLatch_r <= 1'b0;
	end

	// ======================================================================
	// Busy timer: one counter for read, program, erase and reset phases.
	wire startAny = doRead | doProg | doErase;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_BUSY;
			busyCnt_r <= 17'(RST_CYC);
			rstOp_r <= 1'b1;
			op_r <= OP_READ;
			opFail_r <= 1'b0;
		end else if (doReset) begin
			state_r <= ST_BUSY;
			busyCnt_r <= 17'(RST_CYC);
			rstOp_r <= 1'b1;
		end else if (startAny) begin
			state_r <= ST_BUSY;
			rstOp_r <= 1'b0;
			busyCnt_r <= doRead ? 17'(READ_CYC) : doProg ? 17'(PROG_CYC) : 17'(ERASE_CYC);
			op_r <= doRead ? OP_READ : doErase ? OP_ERASE : lockSeq ? OP_LOCK : OP_PROG;
			opFail_r <= doProg ? progBad : doErase & eraseBad;
		end else begin
			case (state_r)
				ST_BUSY: begin
					busyCnt_r <= busyCnt_r - 17'h00001;
					if (busyCnt_r == 17'h00001)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Fail flags: cleared at start, set at the end; a set wins a same-cycle clear.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pFail_r <= 1'b0;
			eFail_r <= 1'b0;
		end else begin
			if (opDone & opFail_r & (op_r == OP_PROG | op_r == OP_LOCK))
				pFail_r <= 1'b1;
			else if (doProg | doReset)
				pFail_r <= 1'b0;
			if (opDone & opFail_r & (op_r == OP_ERASE))
				eFail_r <= 1'b1;
			else if (doErase | doReset)
				eFail_r <= 1'b0;
		end
	end

	// ECC field follows the array engine; cleared at read start and reset.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ecc_r <= 2'h0;
		else if (eccIn.valid)
			ecc_r <= eccIn.code;
		else if (doRead | doReset)
			ecc_r <= 2'h0;
	end

	// ======================================================================
	// Requests to the array engine. The select bit routes the row, so with
	// it clear the lock bit plays no part in the routing.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			arrayReq <= '0;
			lockBurn <= 1'b0;
		end else begin
			arrayReq.valid <= startAny & ~(doProg & progBad) & ~(doErase & eraseBad);
			arrayReq.kind <= doRead ? OP_READ : doErase ? OP_ERASE : lockSeq ? OP_LOCK : OP_PROG;
			arrayReq.otpSel <= otpEn_r & ~doErase;
			arrayReq.row <= row_r;
			lockBurn <= opDone & (op_r == OP_LOCK) & ~opFail_r;
		end
	end

	// ======================================================================
	// Get-feature answer, shifted out on falling SCLK; unmapped reads 00h.
	wire inData = (cmd_r == `CMD_GETF) & (byteCnt_r >= 2'h2);
	wire [7:0] rdSel = (fadr_r == `ADR_STATUS) ? statusReg :
		(fadr_r == `ADR_CONFIG) ? configReg : 8'h00;
	logic [2:0] outBit_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			miso <= 1'b0;
			misoOe_n <= 1'b1;
			outBit_r <= 3'h0;
		end else if (~sel) begin
			misoOe_n <= 1'b1;
			outBit_r <= 3'h0;
		end else if (sclkFall & inData) begin
			misoOe_n <= 1'b0;
			miso <= rdSel[3'h7 - outBit_r];
			outBit_r <= outBit_r + 3'h1;
		end
	end

	// ======================================================================
	// Checks.
	property p_busy_on_start;
		@(posedge mclk) disable iff (!arst_n)
		(doRead | doProg | doErase) |=> busy [*8];
	endproperty
	a_busy_on_start: assert property (p_busy_on_start) else $error("busy not held");
	property p_exec_needs_latch;
		@(posedge mclk) disable iff (!arst_n)
		(endCmd & (cmd_r == `CMD_PEXEC) & ~wrLatch_r) |=> ~arrayReq.valid;
	endproperty
	a_exec_needs_latch: assert property (p_exec_needs_latch) else $error("exec without latch");
	property p_wren_sets;
		@(posedge mclk) disable iff (!arst_n) doWren |=> wrLatch_r;
	endproperty
	a_wren_sets: assert property (p_wren_sets) else $error("latch not set");
	property p_lock_sticky;
		@(posedge mclk) disable iff (!arst_n) locked_r |=> locked_r;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");
	property p_locked_no_prog;
		@(posedge mclk) disable iff (!arst_n)
		(doProg & otpEn_r & locked_r) |=> ~arrayReq.valid ##[1:300] pFail_r;
	endproperty
	a_locked_no_prog: assert property (p_locked_no_prog) else $error("locked OTP programmed");
	property p_otp_erase_fails;
		@(posedge mclk) disable iff (!arst_n)
		(doErase & otpEn_r) |=> (op_r == OP_ERASE) & opFail_r & ~eFail_r;
	endproperty
	a_otp_erase_fails: assert property (p_otp_erase_fails) else $error("OTP erase allowed");
	property p_reset_clears;
		@(posedge mclk) disable iff (!arst_n)
		doReset |=> ~otpEn_r & ~pFail_r & ~eFail_r & busy;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left state");
	property p_read_clears_ecc;
		@(posedge mclk) disable iff (!arst_n) (doRead & ~eccIn.valid) |=> ecc_r == 2'h0;
	endproperty
	a_read_clears_ecc: assert property (p_read_clears_ecc) else $error("ecc not cleared");
	property p_route_main;
		@(posedge mclk) disable iff (!arst_n) (startAny & ~otpEn_r) |=> ~arrayReq.otpSel;
	endproperty
	a_route_main: assert property (p_route_main) else $error("OTP routed");
	// The two reserved status bits must leave the pin as zeros.
	property p_status_reserved;
		@(posedge mclk) disable iff (!arst_n)
		(sclkFall & inData & (fadr_r == `ADR_STATUS) & (outBit_r < 3'h2)) |=> ~miso;
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("status layout");
endmodule : otp_status_regs
`default_nettype wire

/* test/otpst_spi_host.sv */
/*
 * SPI host model that faces the feature and status registers.
 * Assumes mode 0 framing, with each sclk half period paced as four mclk cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module otpst_spi_host (
	input wire logic mclk,
	output logic sclk,
	output logic csPin_n,
	output logic mosi,
	input wire logic miso
);
	// ==========================================================================
	// Idle state: sclk parked low and the device deselected.
	initial begin
		sclk = 1'b0;
		csPin_n = 1'b1;
		mosi = 1'b0;
	end
	// Sends n bytes from the top of tx, MSB first, and returns the last byte read.
	// Miso is sampled late in the high phase, because the device answer lags the pin edge.
	task automatic frame(input int n, input logic [31:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(negedge mclk);
		csPin_n = 1'b0;
		for (i = 0; i < n * 8; i++) begin
			mosi = tx[31 - i];
			repeat (4) @(negedge mclk);
			sclk = 1'b1;
			repeat (4) @(negedge mclk);
			rx = {rx[6:0], miso};
			sclk = 1'b0;
		end
		repeat (4) @(negedge mclk);
		csPin_n = 1'b1;
		mosi = ~mosi;
		repeat (8) @(negedge mclk);
	endtask : frame
endmodule : otpst_spi_host
`default_nettype wire

/* test/test_otp_and_status_feature_regs.sv */
/*
 * Self-checking bench of the feature and status registers, driven over SPI.
 * Assumes the SPI host model and short program, erase and reset counts.
 */
`timescale 1ns/1ns
`default_nettype none
`include "otpst_defines.svh"
module test_otp_and_status_feature_regs;
	import otpst_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic lockNv = 1'b0;
	logic blockProtected = 1'b0;
	otpst_ecc_t eccIn = '0;
	wire logic sclk, csPin_n, mosi, miso, misoOe_n, lockBurn;
	otpst_req_t arrayReq, lastReq;
	logic [7:0] configOut, rd;
	int n_errors = 0;
	int samples_checked = 0;
	int nReq = 0;
	int nBurn = 0;
	logic oeLow = 1'b0;
	// ==========================================================================
	// Clock, design and host.
	always #50 mclk = ~mclk;
	otp_status_regs #(.PROG_CYC(20), .ERASE_CYC(20), .RST_CYC(20)) u_otp_status_regs (
		.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csPin_n(csPin_n), .mosi(mosi),
		.miso(miso), .misoOe_n(misoOe_n), .lockNv(lockNv), .blockProtected(blockProtected),
		.eccIn(eccIn), .arrayReq(arrayReq), .lockBurn(lockBurn), .configOut(configOut));
	otpst_spi_host u_otpst_spi_host (
		.mclk(mclk), .sclk(sclk), .csPin_n(csPin_n), .mosi(mosi), .miso(miso));
	// Requests and lock pulses last one cycle, so each counts once per edge.
	always @(posedge mclk) begin
		if (arrayReq.valid === 1'b1) begin
			nReq++;
			lastReq = arrayReq;
		end
		if (lockBurn === 1'b1)
			nBurn++;
		if (misoOe_n === 1'b0)
			oeLow = 1'b1;
	end
	// ==========================================================================
	// Checking and access tasks.
	task automatic fail(input string msg);
		n_errors++;
		$display("Error at %0t: %s", $time, msg);
	endtask : fail
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
			fail($sformatf("read %h, expected %h", got, exp));
	endtask : chk8
	task automatic chkReq(input otpst_op_t kind, input logic otpSel, input logic [23:0] row);
		samples_checked++;
		if (lastReq !== {1'b1, kind, otpSel, row})
			fail("array request differs");
	endtask : chkReq
	task automatic end_sim();
		$display("Checked %0d, errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic getf(input logic [7:0] adr);
		u_otpst_spi_host.frame(3, {`CMD_GETF, adr, 16'h0000}, rd);
	endtask : getf
	task automatic setf(input logic [7:0] dat);
		u_otpst_spi_host.frame(3, {`CMD_SETF, `ADR_CONFIG, dat, 8'h00}, rd);
	endtask : setf
	task automatic cmdRow(input int n, input logic [7:0] op, input logic [23:0] row);
		u_otpst_spi_host.frame(n, {op, row}, rd);
	endtask : cmdRow
	// Polls the busy flag under a bound; rd keeps the final status byte.
	task automatic waitReady();
		int i;
		for (i = 0; i < 100; i++) begin
			getf(`ADR_STATUS);
			if (rd[`ST_BUSYBIT] === 1'b0)
				return;
		end
		fail("busy flag never cleared");
		end_sim();
	endtask : waitReady
	// Every block counts as good here: no array stands behind the block, so no
	// spare-byte mark is read before a program or erase.
	// Write enable, one program or erase, then the status once idle.
	task automatic op(input logic [7:0] code, input logic [23:0] row, input logic [7:0] exp);
		cmdRow(1, `CMD_WREN, 24'h0);
		cmdRow(4, code, row);
		waitReady();
		chk8(rd, exp);
	endtask : op
	// ==========================================================================
	// Main sequence.
	initial begin
		repeat (20) @(posedge mclk);
		@(negedge mclk) arst_n = 1'b1;
		waitReady();
		chk8(rd, 8'h00);
		chk8({6'h00, oeLow, misoOe_n}, 8'h03);
		getf(`ADR_CONFIG);
		chk8(rd, `CFG_RESET);
		$display("reset test done");
		cmdRow(1, `CMD_WREN, 24'h0);
		getf(`ADR_STATUS);
		chk8(rd, 8'h02);
		cmdRow(1, `CMD_WRDI, 24'h0);
		cmdRow(4, `CMD_PEXEC, 24'h000001);
		getf(`ADR_STATUS);
		chk8(rd, 8'h00);
		chk8(8'(nReq), 8'h00);
		$display("latch test done");
		setf(8'h50);
		getf(`ADR_CONFIG);
		chk8(rd, 8'h50);
		chk8(configOut, 8'h50);
		op(`CMD_PEXEC, 24'h000003, 8'h00);
		chkReq(OP_PROG, 1'b1, 24'h000003);
		op(`CMD_PEXEC, `OTP_PAGES, 8'h08);
		chk8(8'(nReq), 8'h01);
		cmdRow(1, `CMD_RESET, 24'h0);
		waitReady();
		chk8(rd, 8'h00);
		getf(`ADR_CONFIG);
		chk8(rd, `CFG_RESET);
		setf(8'h40);
		op(`CMD_BERASE, 24'h000000, 8'h04);
		$display("otp test done");
		setf(8'h10);
		cmdRow(4, `CMD_PREAD, 24'h000005);
		chkReq(OP_READ, 1'b0, 24'h000005);
		@(negedge mclk) eccIn = 3'b110;
		@(negedge mclk) eccIn = 3'b000;
		waitReady();
		chk8(rd, 8'h24);
		cmdRow(4, `CMD_PREAD, 24'h000005);
		getf(`ADR_STATUS);
		chk8(rd, 8'h05);
		waitReady();
		blockProtected = 1'b1;
		op(`CMD_PEXEC, 24'h000006, 8'h0C);
		blockProtected = 1'b0;
		$display("read test done");
		setf(8'hC0);
		op(`CMD_PEXEC, 24'h000000, 8'h04);
		chkReq(OP_LOCK, 1'b1, 24'h000000);
		chk8(8'(nBurn), 8'h01);
		lockNv = 1'b1;
		op(`CMD_PEXEC, 24'h000001, 8'h0C);
		chk8(8'(nReq), 8'h04);
		setf(8'h00);
		getf(`ADR_CONFIG);
		chk8(rd, 8'h80);
		chk8(configOut, 8'h80);
		$display("lock test done");
		end_sim();
	end
endmodule : test_otp_and_status_feature_regs
`default_nettype wire
